// [rtl/tsctl_top.sv]
// Purpose: Primary control of the on-chip temperature sensor
// Assumes: Avalon-MM slave, standby and request inputs on clock
// Notes:   Enable and soft reset reach the sensor after a delay
`timescale 1ns/100ps
`include "tsctl_consts.svh"

module tsctl_top
	import tsctl_pkg::*;
#(
	parameter int SYNC_CYCLES = `TSCTL_SYNC_CYC
)
(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        rst_n,
	// Avalon-MM slave
	input  wire logic [7:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [3:0]  byteenable,
	input  wire logic [31:0] writedata,
	output logic      [31:0] readdata,
	output logic             waitrequest,
	// System side
	input  wire logic        writeProtect,
	input  wire logic        standbySleep,
	input  wire logic        periphRequest,
	// Sensor side
	output logic             sensorEnabled,
	output logic             sensorRunning
);

	// ---------------------------------------------------------------
	// Storage
	// ---------------------------------------------------------------
	logic        waitReq_r;
	logic        enable_r;
	logic        run_in_standby_r;
	logic        free_running_r;
	logic        sensorRun_r;
	tsctl_byte_t gain_r;
	logic [31:0] readdata_r;
	logic        enBusy;
	logic        rstBusy;
	logic        rstDone;
	logic        enActual;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	// One wait cycle per access keeps read data registered
	wire accFirst = (read || write) && waitReq_r;
	wire wrDo     = write && !waitReq_r && byteenable[0];
	wire selCtrlP = (address == `TSCTL_OFF_CTRLP);
	wire selSync  = (address == `TSCTL_OFF_SYNC);
	wire selCtrlT = (address == `TSCTL_OFF_CTRLT);
	wire selStat  = (address == `TSCTL_OFF_STAT);
	wire selGain  = (address == `TSCTL_OFF_GAIN);

	// Protected writes; control writes not accepted during a soft reset or in its
	// closing cycle, where the clear would race the new value
	wire ctrlWr  = wrDo && selCtrlP && !writeProtect
	               && !rstBusy && !rstDone;
	// A zero in the reset bit starts nothing
	wire swrstWr = ctrlWr
	               && writedata[`TSCTL_BIT_SOFT_RESET];
	wire ctrlLd  = ctrlWr && !writedata[`TSCTL_BIT_SOFT_RESET];
	wire isOff   = !enable_r && !enActual;
	wire tertWr  = wrDo && selCtrlT && !writeProtect
	               && !rstBusy && !rstDone && isOff;
	wire gainWr  = wrDo && selGain && !writeProtect;

	// ---------------------------------------------------------------
	// Next values
	// ---------------------------------------------------------------
	// Reserved bits of the written byte are simply dropped
	logic enable_nxt;
	logic run_in_standby_nxt;
	logic free_running_nxt;
	logic sensorRun_nxt;
	logic waitReq_nxt;
	tsctl_byte_t gain_nxt;
	logic [31:0] readdata_nxt;

	assign enable_nxt   = rstDone ? 1'b0
	                    : ctrlLd ? writedata[`TSCTL_BIT_ENA]
	                    : enable_r;
	assign run_in_standby_nxt = rstDone ? 1'b0
	                    : ctrlLd ? writedata[`TSCTL_BIT_RSB]
	                    : run_in_standby_r;
	assign free_running_nxt  = rstDone ? 1'b0
	                    : tertWr ? writedata[`TSCTL_BIT_FREE]
	                    : free_running_r;
	// Calibration survives soft reset
	assign gain_nxt     = gainWr ? writedata[7:0] : gain_r;
	assign waitReq_nxt  = !accFirst;

	// Run decision from enabled state and sleep policy
	wire stdbyRun = run_in_standby_r
	                && (free_running_r || periphRequest);
	assign sensorRun_nxt = enActual && (!standbySleep || stdbyRun);

	// ---------------------------------------------------------------
	// Read mux
	// ---------------------------------------------------------------
	wire [31:0] rdCtrlP = {25'h0, run_in_standby_r, 4'h0,
	                       enable_r, rstBusy};
	wire [31:0] rdSync  = {30'h0, enBusy, rstBusy};
	wire [31:0] rdCtrlT = {31'h0, free_running_r};
	wire [31:0] rdStat  = {30'h0, sensorRun_r, enActual};
	wire [31:0] rdGain  = {24'h0, gain_r};

	// Unmapped addresses read as zero
	assign readdata_nxt = !(accFirst && read) ? readdata_r
	                    : selCtrlP ? rdCtrlP
	                    : selSync  ? rdSync
	                    : selCtrlT ? rdCtrlT
	                    : selStat  ? rdStat
	                    : selGain  ? rdGain
	                    : 32'h0;

	// ---------------------------------------------------------------
	// Sensor-side handover
	// ---------------------------------------------------------------
	// Enable and reset take effect after the synchroniser delay
	tsctl_sync
	#(
		.SYNC_CYCLES (SYNC_CYCLES)
	)
	u_sync
	(
		.clock    (clock),
		.rst_n    (rst_n),
		.enStart  (ctrlLd),
		.enTarget (writedata[`TSCTL_BIT_ENA]),
		.rstStart (swrstWr),
		.enActual (enActual),
		.enBusy   (enBusy),
		.rstBusy  (rstBusy),
		.rstDone  (rstDone)
	);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	// Control and calibration
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			enable_r   <= 1'(`TSCTL_CTRLP_RST >> `TSCTL_BIT_ENA);
			run_in_standby_r <= 1'b0;
			free_running_r  <= 1'b0;
			gain_r     <= `TSCTL_GAIN_RST;
		end
		else
		begin
			enable_r   <= enable_nxt;
			run_in_standby_r <= run_in_standby_nxt;
			free_running_r  <= free_running_nxt;
			gain_r     <= gain_nxt;
		end
	end

	// Bus handshake, read data and run state
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			waitReq_r   <= 1'b1;
			readdata_r  <= 32'h0;
			sensorRun_r <= 1'b0;
		end
		else
		begin
			waitReq_r   <= waitReq_nxt;
			readdata_r  <= readdata_nxt;
			sensorRun_r <= sensorRun_nxt;
		end
	end

	assign readdata      = readdata_r;
	assign waitrequest   = waitReq_r;
	assign sensorEnabled = enActual;
	assign sensorRunning = sensorRun_r;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	sequence s_ctrlLoad;
		ctrlLd;
	endsequence

	sequence s_busyShown;
		enBusy && enable_r == $past(writedata[`TSCTL_BIT_ENA]);
	endsequence

	property p_halt;
		standbySleep && !run_in_standby_r |=> !sensorRunning;
	endproperty
	a_halt: assert property (p_halt)
		else $error("sensor runs in standby without run-in-standby");

	property p_onRequest;
		standbySleep && run_in_standby_r && !free_running_r && enActual
		|=> sensorRunning == $past(periphRequest);
	endproperty
	a_onRequest: assert property (p_onRequest)
		else $error("standby run does not follow request");

	property p_free_running;
		standbySleep && run_in_standby_r && free_running_r && enActual
		|=> sensorRunning;
	endproperty
	a_free_running: assert property (p_free_running)
		else $error("free-running sensor stopped in standby");

	property p_rsbDirect;
		ctrlLd |=> run_in_standby_r == $past(writedata[`TSCTL_BIT_RSB])
		           && $stable(enActual);
	endproperty
	a_rsbDirect: assert property (p_rsbDirect)
		else $error("run-in-standby write not immediate");

	property p_enBusy;
		s_ctrlLoad |=> s_busyShown;
	endproperty
	a_enBusy: assert property (p_enBusy)
		else $error("enable write without readback and busy");

	property p_enDone;
		$fell(enBusy) && !rstBusy |-> sensorEnabled == enable_r;
	endproperty
	a_enDone: assert property (p_enDone)
		else $error("busy cleared before enable completed");

	property p_enWritable;
		ctrlLd && enActual
		|=> enable_r == $past(writedata[`TSCTL_BIT_ENA]);
	endproperty
	a_enWritable: assert property (p_enWritable)
		else $error("enable bit blocked while enabled");

	property p_swrZero;
		ctrlLd && !rstBusy |=> !rstBusy;
	endproperty
	a_swrZero: assert property (p_swrZero)
		else $error("zero soft reset write started a reset");

	sequence s_resetEnd;
		rstDone && !sensorEnabled && !gainWr;
	endsequence

	property p_swrClear;
		s_resetEnd |=> !enable_r && !run_in_standby_r && !free_running_r
		              && gain_r == $past(gain_r);
	endproperty
	a_swrClear: assert property (p_swrClear)
		else $error("soft reset result wrong");

	property p_swrWins;
		swrstWr |=> $stable(enable_r) && $stable(run_in_standby_r)
		            && rstBusy;
	endproperty
	a_swrWins: assert property (p_swrWins)
		else $error("soft reset write applied other bits");

	property p_protect;
		wrDo && writeProtect && !rstDone |=> $stable(enable_r)
		    && $stable(run_in_standby_r) && $stable(gain_r)
		    && $stable(free_running_r);
	endproperty
	a_protect: assert property (p_protect)
		else $error("protected write was accepted");

	property p_enProt;
		wrDo && selCtrlT && !isOff && !rstDone |=> $stable(free_running_r);
	endproperty
	a_enProt: assert property (p_enProt)
		else $error("enable-protected write accepted while enabled");

	property p_reserved;
		accFirst && read && selCtrlP
		|=> readdata[5:2] == 4'h0 && readdata[31:7] == 25'h0;
	endproperty
	a_reserved: assert property (p_reserved)
		else $error("reserved control bits read non-zero");

	property p_swrOff;
		rstDone |-> !sensorEnabled && !rstBusy;
	endproperty
	a_swrOff: assert property (p_swrOff)
		else $error("sensor still enabled after soft reset");

	property p_rstBlock;
		wrDo && selCtrlP && rstBusy
		|=> $stable(enable_r) && $stable(run_in_standby_r);
	endproperty
	a_rstBlock: assert property (p_rstBlock)
		else $error("control write accepted during soft reset");

	// Disabled sensor never runs; enabled and awake always runs
	property p_offStop;
		!enActual |=> !sensorRunning;
	endproperty
	a_offStop: assert property (p_offStop)
		else $error("disabled sensor is running");

	property p_awake;
		!standbySleep && enActual |=> sensorRunning;
	endproperty
	a_awake: assert property (p_awake)
		else $error("enabled sensor not running outside standby");

	// Cycles since the last enable load, saturating; busy must fall
	// exactly when the handover delay has run out
	logic [4:0] sinceLd_r;
	always_ff @(posedge clock)
	begin
		if (!rst_n || ctrlLd)
			sinceLd_r <= 5'h0;
		else if (sinceLd_r != 5'h1f)
			sinceLd_r <= sinceLd_r + 5'h1;
	end

	property p_busyLen;
		$fell(enBusy) && !rstBusy |-> sinceLd_r == 5'(SYNC_CYCLES);
	endproperty
	a_busyLen: assert property (p_busyLen)
		else $error("enable busy length differs from handover delay");

endmodule

// [rtl/tsctl_consts.svh]
// Purpose: Offsets, bit positions, reset values and timing counts
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Definitions only, no logic
`ifndef TSCTL_CONSTS_SVH
`define TSCTL_CONSTS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define TSCTL_OFF_CTRLP  8'h00
`define TSCTL_OFF_SYNC   8'h04
`define TSCTL_OFF_CTRLT  8'h08
`define TSCTL_OFF_STAT   8'h0c
`define TSCTL_OFF_GAIN   8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define TSCTL_BIT_SOFT_RESET  0
`define TSCTL_BIT_ENA    1
`define TSCTL_BIT_RSB    6
`define TSCTL_BIT_FREE   0
`define TSCTL_BIT_EBUSY  1
`define TSCTL_BIT_RBUSY  0
`define TSCTL_BIT_RUN    1
`define TSCTL_BIT_ACT    0

// ---------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------
`define TSCTL_CTRLP_RST  8'h00
`define TSCTL_GAIN_RST   8'h00
`define TSCTL_SYNC_CYC   3

`endif

// [rtl/tsctl_pkg.sv]
// Purpose: Types shared by the sensor control files
// Assumes: One-hot state codes
// Notes:   Constants live in the header
package tsctl_pkg;

	// Sensor-side synchroniser states
	typedef enum logic [2:0]
	{
		SY_IDLE = 3'b001,
		SY_EN   = 3'b010,
		SY_RST  = 3'b100
	} tsctl_sync_t;

	typedef logic [7:0] tsctl_byte_t;

endpackage

// [rtl/tsctl_sync.sv]
// Purpose: Delayed enable and soft reset handover to the sensor side
// Assumes: Requests are single-cycle pulses from the register file
// Notes:   Soft reset pre-empts a pending enable change
`timescale 1ns/100ps
`include "tsctl_consts.svh"

module tsctl_sync
	import tsctl_pkg::*;
#(
	parameter int SYNC_CYCLES = `TSCTL_SYNC_CYC
)
(
	// Clock and reset
	input  wire logic clock,
	input  wire logic rst_n,
	// Requests
	input  wire logic enStart,
	input  wire logic enTarget,
	input  wire logic rstStart,
	// Sensor side state
	output logic      enActual,
	output logic      enBusy,
	output logic      rstBusy,
	output logic      rstDone
);

	localparam logic [3:0] LOAD = 4'(SYNC_CYCLES - 1);

	tsctl_sync_t state_r;
	tsctl_sync_t state_nxt;
	logic [3:0]  cnt_r;
	logic [3:0]  cnt_nxt;
	logic        tgt_r;
	logic        tgt_nxt;
	logic        act_nxt;
	logic        done_nxt;
	wire         cntZero = (cnt_r == 4'h0);
	wire         finish  = !state_r[0] && cntZero
	                       && !rstStart && !enStart;

	// Reset first, then enable, then completion
	always_comb
	begin
		state_nxt = state_r;
		unique case (state_r)
			SY_IDLE, SY_EN, SY_RST:
			begin
				if (rstStart)
					state_nxt = SY_RST;
				else if (enStart && state_r != SY_RST)
					state_nxt = SY_EN;
				else if (finish)
					state_nxt = SY_IDLE;
			end
			default:
				state_nxt = SY_IDLE;
		endcase
	end

	// Countdown and latched target
	assign cnt_nxt  = (rstStart || enStart) ? LOAD
	                : (cntZero ? 4'h0 : cnt_r - 4'h1);
	assign tgt_nxt  = enStart ? enTarget : tgt_r;
	assign act_nxt  = (finish && state_r == SY_EN) ? tgt_r
	                : (finish && state_r == SY_RST) ? 1'b0 : enActual;
	assign done_nxt = finish && state_r == SY_RST;

	// State registers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_r  <= SY_IDLE;
			cnt_r    <= 4'h0;
			tgt_r    <= 1'b0;
			enActual <= 1'b0;
			rstDone  <= 1'b0;
		end
		else
		begin
			state_r  <= state_nxt;
			cnt_r    <= cnt_nxt;
			tgt_r    <= tgt_nxt;
			enActual <= act_nxt;
			rstDone  <= done_nxt;
		end
	end

	// Busy flags straight from the one-hot bits
	assign enBusy  = state_r[1];
	assign rstBusy = state_r[2];

endmodule

// [sim/testbench.sv]
// Purpose: Self-checking bench for the sensor primary control block
// Assumes: Avalon access with one wait cycle, enable handover of SYNC
// Notes:   Random values from a fixed seed mixed with corner cases
`timescale 1ns/100ps
`include "tsctl_consts.svh"

module testbench
	import tsctl_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	localparam int SYNC = 8;
	logic        clock;
	logic        rst_n;
	logic [7:0]  address;
	logic        read;
	logic        write;
	logic [3:0]  byteenable;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic        writeProtect;
	logic        standbySleep;
	logic        periphRequest;
	logic        sensorEnabled;
	logic        sensorRunning;
	int          nMismatch;
	int          samplesChecked;
	logic [31:0] q;
	logic [31:0] e;
	logic [7:0]  gain;
	logic [2:0]  v;

	// Longer handover than default, leaves room for back-to-back reads
	tsctl_top #(.SYNC_CYCLES(SYNC)) i_tsctl_top
	(
		.clock         (clock),
		.rst_n         (rst_n),
		.address       (address),
		.read          (read),
		.write         (write),
		.byteenable    (byteenable),
		.writedata     (writedata),
		.readdata      (readdata),
		.waitrequest   (waitrequest),
		.writeProtect  (writeProtect),
		.standbySleep  (standbySleep),
		.periphRequest (periphRequest),
		.sensorEnabled (sensorEnabled),
		.sensorRunning (sensorRunning)
	);

	// Clock
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ---------------------------------------------------------------
	// Tasks
	// ---------------------------------------------------------------
	// Compare and count
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
			nMismatch++;
		end
	endtask

	// One access; held until waitrequest is sampled low
	task bus(input logic isWr, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] be);
		@(posedge clock);
		address    <= a;
		writedata  <= d;
		byteenable <= be;
		write      <= isWr;
		read       <= !isWr;
		// Only the watchdog ends a wait that never completes
		do
			@(posedge clock);
		while (waitrequest !== 1'b0);
		q = readdata;
		write <= 1'b0;
		read  <= 1'b0;
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask

	task rd(input logic [7:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(q, exp);
	endtask

	// Sensor-side settling time after any handover
	task settle;
		repeat (SYNC + 4) @(posedge clock);
	endtask

	// Running while enabled
	function logic expRun(logic st, logic pr, logic rsb, logic fr);
		return !st || (rsb && (fr || pr));
	endfunction

	task give_verdict;
		if (nMismatch == 0 && samplesChecked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Watchdog against a hung handshake
	initial
	begin
		repeat (20000) @(posedge clock);
		nMismatch++;
		give_verdict;
	end

	// ---------------------------------------------------------------
	// Main sequence
	// ---------------------------------------------------------------
	initial
	begin
		rst_n = 1'b0;
		read = 1'b0;
		write = 1'b0;
		address = 8'h00;
		writedata = 32'h0;
		byteenable = 4'h0;
		writeProtect = 1'b0;
		standbySleep = 1'b0;
		periphRequest = 1'b0;
		nMismatch = 0;
		samplesChecked = 0;
		void'($urandom(32'h1044));
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		// Reset values, reserved bits, protection, dead lane, hole
		rd(`TSCTL_OFF_CTRLP, 32'h0);
		rd(`TSCTL_OFF_SYNC, 32'h0);
		wr(`TSCTL_OFF_CTRLP, 32'hbc);
		rd(`TSCTL_OFF_CTRLP, 32'h0);
		writeProtect <= 1'b1;
		wr(`TSCTL_OFF_CTRLP, 32'h40);
		wr(`TSCTL_OFF_GAIN, 32'h11);
		writeProtect <= 1'b0;
		rd(`TSCTL_OFF_CTRLP, 32'h0);
		rd(`TSCTL_OFF_GAIN, 32'h0);
		bus(1'b1, `TSCTL_OFF_CTRLP, 32'h40, 4'h0);
		rd(`TSCTL_OFF_CTRLP, 32'h0);
		rd(8'h24, 32'h0);
		gain = 8'($urandom);
		wr(`TSCTL_OFF_GAIN, {24'h0, gain});
		// Enable handover, protection, standby behaviour per mode
		for (int fr = 0; fr < 2; fr++)
		begin
			wr(`TSCTL_OFF_CTRLT, 32'(fr));
			rd(`TSCTL_OFF_CTRLT, 32'(fr));
			wr(`TSCTL_OFF_CTRLP, 32'h02);
			rd(`TSCTL_OFF_SYNC, 32'h02);
			rd(`TSCTL_OFF_CTRLP, 32'h02);
			settle;
			rd(`TSCTL_OFF_SYNC, 32'h0);
			rd(`TSCTL_OFF_STAT, 32'h03);
			wr(`TSCTL_OFF_CTRLT, 32'(fr == 0));
			rd(`TSCTL_OFF_CTRLT, 32'(fr));
			for (int i = 0; i < 14; i++)
			begin
				v = (i < 8) ? 3'(i) : 3'($urandom);
				wr(`TSCTL_OFF_CTRLP, {25'h0, v[2], 6'h02});
				standbySleep  <= v[0];
				periphRequest <= v[1];
				repeat (3) @(posedge clock);
				e = {31'h0, expRun(v[0], v[1], v[2], fr[0])};
				chk({31'h0, sensorRunning}, e);
				rd(`TSCTL_OFF_STAT, {30'h0, e[0], 1'b1});
				rd(`TSCTL_OFF_CTRLP, {25'h0, v[2], 6'h02});
			end
			settle;
			rd(`TSCTL_OFF_SYNC, 32'h0);
			wr(`TSCTL_OFF_CTRLP, 32'h0);
			rd(`TSCTL_OFF_CTRLP, 32'h0);
			settle;
			chk({31'h0, sensorEnabled}, 32'h0);
			standbySleep <= 1'b0;
		end
		// Soft reset discards other bits and spares the gain
		wr(`TSCTL_OFF_CTRLT, 32'h1);
		wr(`TSCTL_OFF_CTRLP, 32'h02);
		settle;
		wr(`TSCTL_OFF_CTRLP, 32'h41);
		wr(`TSCTL_OFF_CTRLP, 32'h42);
		rd(`TSCTL_OFF_SYNC, 32'h01);
		rd(`TSCTL_OFF_CTRLP, 32'h03);
		settle;
		rd(`TSCTL_OFF_CTRLP, 32'h0);
		rd(`TSCTL_OFF_CTRLT, 32'h0);
		rd(`TSCTL_OFF_GAIN, {24'h0, gain});
		chk({31'h0, sensorEnabled}, 32'h0);
		give_verdict;
	end
endmodule
